// ---- hw/usb_ep0_params.svh ----
// Constants of the endpoint FIFO, device control and endpoint 0 register block
`ifndef USB_EP0_PARAMS_SVH
`define USB_EP0_PARAMS_SVH
`define OFS_FIFO_EP0    5'h00
`define OFS_FIFO_EP3    5'h0C
`define OFS_DEV_CONTROL 5'h10
`define OFS_EP0_STATUS  5'h14
`define OFS_EP0_COUNT   5'h18
`define NUM_EP          4
`define FIFO_DEPTH      4
`define FIFO_FULL_LVL   3'h4
`define WORD_BYTES      7'h04
`define DC_SESSION      0
`define DC_HOST_REQ     1
`define DC_HOST_MODE    2
`define DC_VBUS_LO      3
`define DC_VBUS_HI      4
`define DC_SLOW         5
`define DC_FULL         6
`define DC_ROLE_B       7
`define CS_RX_READY     0
`define CS_TX_READY     1
`define CS_STALL_SENT   2
`define CS_LAST_DATA    3
`define CS_EARLY_END    4
`define CS_STALL_REQ    5
`define CS_RX_ACK       6
`define CS_END_ACK      7
`define CS_FLUSH        8
`define DEV_CONTROL_RESET 8'h00
`define EP0_STATUS_RESET 16'h0000
`endif

// ---- hw/usb_ep0_pkg.sv ----
// Types shared by the endpoint FIFO and endpoint 0 control block
`include "usb_ep0_params.svh"
package usb_ep0_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ_WAIT, PH_READ_DONE} phase_type;
  typedef struct packed {
    logic [`NUM_EP-1:0][`FIFO_DEPTH-1:0][31:0] tx_mem;
    logic [`NUM_EP-1:0][`FIFO_DEPTH-1:0][31:0] rx_mem;
    logic [`NUM_EP-1:0][2:0]                   tx_wp;
    logic [`NUM_EP-1:0][2:0]                   tx_rp;
    logic [`NUM_EP-1:0][2:0]                   rx_wp;
    logic [`NUM_EP-1:0][2:0]                   rx_rp;
    phase_type                                 phase;
    logic [4:0]                                addr;
    logic [31:0]                               rdata;
    logic                                      session;
    logic                                      host_req;
    logic                                      hnp_started;
    logic                                      rx_rdy;
    logic                                      tx_rdy;
    logic                                      stall_sent;
    logic                                      last_data;
    logic                                      early_end;
    logic                                      stall_req;
    logic [6:0]                                rx_count;
    logic                                      srp_pulse;
    logic                                      disc_pulse;
    logic                                      hnp_pulse;
    logic                                      evt_pulse;
  } state_type;
endpackage

// ---- hw/usb_otg_otg_device_control_ep0_control.sv ----
// Endpoint FIFO ports, OTG device control and endpoint 0 control/status over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
`include "usb_ep0_params.svh"
//
// Function
// - Word writes to an endpoint port push its transmit FIFO; reads pop its receive FIFO.
// - Device control register resets to zero; bit 0 starts or ends an A-device session.
// - As B device hardware drives session bit; write one requests session; zero disconnects only while suspended.
// - B-device host request starts negotiation in suspend; cleared when negotiation completes.
// - Bit 2 reads the current role: zero peripheral, one host.
// - Two-bit read-only field reports the VBUS level band.
// - Bit 5 flags an attached low-speed device; low speed itself unsupported.
// - Bit 6 flags an attached full-speed device, meaningful in host role only.
// - Bit 7 reports OTG role, zero A one B, valid during a session.
// - Endpoint 0 control/status register is 16 bits and resets to zero.
// - Receive-ready sets on packet arrival; writing bit 6 clears it; bit 6 self-clears.
// - Software sets transmit-ready after loading; device clears it when sent.
// - Stall-sent sets on every transmitted STALL and stays until software clears it.
// - Software sets last-data on final or zero-length packet; device clears it.
// - Control end before last-data sets early-end, signals event, flushes FIFO; bit 7 clears.
// - Writing stall request transmits STALL, ending the transaction, then self-clears.
// - Flush bit resets endpoint 0 pointers and ready flags only when a flag is set.
// - Read-only count register reports received bytes in endpoint 0 FIFO.
module usb_otg_otg_device_control_ep0_control (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        tx_pop,
  input  wire logic [1:0]  tx_pop_ep,
  output logic [31:0]      tx_word,
  output logic [3:0]       tx_not_empty,
  input  wire logic        rx_push,
  input  wire logic [1:0]  rx_push_ep,
  input  wire logic [31:0] rx_word,
  input  wire logic [2:0]  rx_push_bytes,
  output logic [3:0]       rx_space,
  input  wire logic        ep0_rx_packet,
  input  wire logic        ep0_tx_sent,
  input  wire logic        stall_transmitted,
  input  wire logic        ctrl_end,
  output logic             stall_request,
  output logic             tx_ready_level,
  output logic             last_data_level,
  output logic             ep0_event,
  input  wire logic        otg_role_b,
  input  wire logic [1:0]  vbus_level,
  input  wire logic        role_is_host,
  input  wire logic        slow_attach,
  input  wire logic        full_attach,
  input  wire logic        suspended,
  input  wire logic        b_session_start,
  input  wire logic        b_session_end,
  input  wire logic        hnp_done,
  output logic             session_level,
  output logic             srp_start,
  output logic             soft_disconnect,
  output logic             hnp_start
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Occupancy from wrap-bit pointers; the extra bit tells full from empty
  function automatic logic [2:0] fifo_level(input logic [2:0] wp, input logic [2:0] rp);
    fifo_level = 3'(wp - rp);
  endfunction

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = 3'(p + 3'h1);
  endfunction

  usb_ep0_pkg::state_type s_r;
  usb_ep0_pkg::state_type s_nxt;

  logic        addr_take;
  logic        in_wr;
  logic [7:0]  dev_control_view;
  logic [15:0] csr_view;
  logic [1:0]  addr_ep;
  logic        addr_is_fifo;

  // Address phase is accepted whenever the bus is ready; reads take one wait state
  assign addr_take    = hsel && htrans[1] && hready;
  assign in_wr        = (s_r.phase == usb_ep0_pkg::PH_WRITE);
  assign addr_ep      = s_r.addr[3:2];
  assign addr_is_fifo = (s_r.addr <= `OFS_FIFO_EP3);

  // Register views; self-clearing strobes always read zero
  always_comb begin
    dev_control_view                 = `DEV_CONTROL_RESET;
    dev_control_view[`DC_SESSION]    = s_r.session;
    dev_control_view[`DC_HOST_REQ]   = s_r.host_req;
    dev_control_view[`DC_HOST_MODE]  = role_is_host;
    dev_control_view[`DC_VBUS_HI:`DC_VBUS_LO] = vbus_level;
    dev_control_view[`DC_SLOW]       = slow_attach;
    dev_control_view[`DC_FULL]       = full_attach && role_is_host;
    dev_control_view[`DC_ROLE_B]     = otg_role_b;
    csr_view                         = `EP0_STATUS_RESET;
    csr_view[`CS_RX_READY]      = s_r.rx_rdy;
    csr_view[`CS_TX_READY]      = s_r.tx_rdy;
    csr_view[`CS_STALL_SENT]    = s_r.stall_sent;
    csr_view[`CS_LAST_DATA]     = s_r.last_data;
    csr_view[`CS_EARLY_END]     = s_r.early_end;
    csr_view[`CS_STALL_REQ]     = s_r.stall_req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_nxt            = s_r;
    s_nxt.srp_pulse  = 1'b0;
    s_nxt.disc_pulse = 1'b0;
    s_nxt.hnp_pulse  = 1'b0;
    s_nxt.evt_pulse  = 1'b0;

    // Bus phase tracking
    if (addr_take) begin
      s_nxt.addr  = haddr[4:0];
      s_nxt.phase = hwrite ? usb_ep0_pkg::PH_WRITE : usb_ep0_pkg::PH_READ_WAIT;
    end else if (s_r.phase == usb_ep0_pkg::PH_READ_WAIT) begin
      s_nxt.phase = usb_ep0_pkg::PH_READ_DONE;
    end else begin
      s_nxt.phase = usb_ep0_pkg::PH_IDLE;
    end

    // Link side: transmit pop and receive push, one word per strobe
    if (tx_pop && (fifo_level(s_r.tx_wp[tx_pop_ep], s_r.tx_rp[tx_pop_ep]) != 3'h0))
      s_nxt.tx_rp[tx_pop_ep] = ptr_inc(s_r.tx_rp[tx_pop_ep]);
    if (rx_push && (fifo_level(s_r.rx_wp[rx_push_ep], s_r.rx_rp[rx_push_ep]) != `FIFO_FULL_LVL)) begin
      // Packet byte 0 arrives in rx_word[7:0]; lanes are stored as given
      s_nxt.rx_mem[rx_push_ep][s_r.rx_wp[rx_push_ep][1:0]] = rx_word;
      s_nxt.rx_wp[rx_push_ep] = ptr_inc(s_r.rx_wp[rx_push_ep]);
      if (rx_push_ep == 2'h0)
        s_nxt.rx_count = 7'(s_r.rx_count + 7'(rx_push_bytes));
    end

    // Read: capture the view and pop the receive FIFO in the wait cycle
    if (s_r.phase == usb_ep0_pkg::PH_READ_WAIT) begin
      s_nxt.rdata = 32'h0000_0000;
      if (addr_is_fifo) begin
        s_nxt.rdata = s_r.rx_mem[addr_ep][s_r.rx_rp[addr_ep][1:0]];
        if (fifo_level(s_r.rx_wp[addr_ep], s_r.rx_rp[addr_ep]) != 3'h0) begin
          s_nxt.rx_rp[addr_ep] = ptr_inc(s_r.rx_rp[addr_ep]);
          if (addr_ep == 2'h0)
            s_nxt.rx_count = (s_nxt.rx_count > `WORD_BYTES) ? 7'(s_nxt.rx_count - `WORD_BYTES) : 7'h00;
        end
      end else if (s_r.addr == `OFS_DEV_CONTROL) begin
        s_nxt.rdata[7:0] = dev_control_view;
      end else if (s_r.addr == `OFS_EP0_STATUS) begin
        s_nxt.rdata[15:0] = csr_view;
      end else if (s_r.addr == `OFS_EP0_COUNT) begin
        s_nxt.rdata[6:0] = s_r.rx_count;
      end
    end

    // Software writes, in the data phase
    if (in_wr) begin
      if (addr_is_fifo) begin
        if (fifo_level(s_r.tx_wp[addr_ep], s_r.tx_rp[addr_ep]) != `FIFO_FULL_LVL) begin
          s_nxt.tx_mem[addr_ep][s_r.tx_wp[addr_ep][1:0]] = hwdata;
          s_nxt.tx_wp[addr_ep] = ptr_inc(s_r.tx_wp[addr_ep]);
        end
      end else if (s_r.addr == `OFS_DEV_CONTROL) begin
        if (!otg_role_b) begin
          s_nxt.session  = hwdata[`DC_SESSION];
          s_nxt.host_req = 1'b0;
        end else begin
          if (hwdata[`DC_SESSION] && !s_r.session) begin
            s_nxt.session   = 1'b1;
            s_nxt.srp_pulse = 1'b1;
          end else if (!hwdata[`DC_SESSION] && s_r.session && suspended) begin
            s_nxt.session    = 1'b0;
            s_nxt.disc_pulse = 1'b1;
          end
          s_nxt.host_req = hwdata[`DC_HOST_REQ];
          if (!hwdata[`DC_HOST_REQ])
            s_nxt.hnp_started = 1'b0;
        end
      end else if (s_r.addr == `OFS_EP0_STATUS) begin
        if (hwdata[`CS_TX_READY])
          s_nxt.tx_rdy = 1'b1;
        if (!hwdata[`CS_STALL_SENT])
          s_nxt.stall_sent = 1'b0;
        if (hwdata[`CS_LAST_DATA])
          s_nxt.last_data = 1'b1;
        if (hwdata[`CS_STALL_REQ])
          s_nxt.stall_req = 1'b1;
        if (hwdata[`CS_RX_ACK])
          s_nxt.rx_rdy = 1'b0;
        if (hwdata[`CS_END_ACK])
          s_nxt.early_end = 1'b0;
        if (hwdata[`CS_FLUSH] && (s_r.tx_rdy || s_r.rx_rdy)) begin
          s_nxt.tx_rp[0]  = s_r.tx_wp[0];
          s_nxt.rx_rp[0]  = s_nxt.rx_wp[0];
          s_nxt.rx_count  = 7'h00;
          s_nxt.tx_rdy    = 1'b0;
          s_nxt.rx_rdy    = 1'b0;
        end
      end
    end

    // B-device session tracking by hardware; the link event wins over software
    if (otg_role_b && b_session_start)
      s_nxt.session = 1'b1;
    else if (otg_role_b && b_session_end)
      s_nxt.session = 1'b0;

    // Negotiation starts once per request when suspend is seen
    if (otg_role_b && s_nxt.host_req && suspended && !s_r.hnp_started) begin
      s_nxt.hnp_started = 1'b1;
      s_nxt.hnp_pulse   = 1'b1;
    end
    // Completion also cancels a start raised in the same cycle, so no stray pulse
    if (hnp_done) begin
      s_nxt.host_req    = 1'b0;
      s_nxt.hnp_started = 1'b0;
      s_nxt.hnp_pulse   = 1'b0;
    end

    // Endpoint 0 events from the link; they come last so a link event beats a software write
    if (ep0_tx_sent) begin
      s_nxt.tx_rdy    = 1'b0;
      s_nxt.evt_pulse = 1'b1;
    end
    if (stall_transmitted) begin
      s_nxt.stall_sent = 1'b1;
      s_nxt.stall_req  = 1'b0;
    end
    if (ctrl_end) begin
      s_nxt.last_data = 1'b0;
      if (!s_r.last_data) begin
        // Early end discards whatever endpoint 0 still holds
        s_nxt.early_end = 1'b1;
        s_nxt.evt_pulse = 1'b1;
        s_nxt.tx_rp[0]  = s_nxt.tx_wp[0];
        s_nxt.rx_rp[0]  = s_nxt.rx_wp[0];
        s_nxt.rx_count  = 7'h00;
        s_nxt.tx_rdy    = 1'b0;
      end
    end
    if (ep0_rx_packet) begin
      s_nxt.rx_rdy    = 1'b1;
      s_nxt.evt_pulse = 1'b1;
    end
  end

  // Single state register; all fields reset to zero
  always_ff @(posedge clk) begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Only the read wait cycle stalls the bus; the response is always OKAY
  assign hreadyout       = (s_r.phase != usb_ep0_pkg::PH_READ_WAIT);
  assign hresp           = 1'b0;
  assign hrdata          = s_r.rdata;
  assign tx_word         = s_r.tx_mem[tx_pop_ep][s_r.tx_rp[tx_pop_ep][1:0]];
  assign stall_request   = s_r.stall_req;
  assign tx_ready_level  = s_r.tx_rdy;
  assign last_data_level = s_r.last_data;
  assign ep0_event       = s_r.evt_pulse;
  assign session_level   = s_r.session;
  assign srp_start       = s_r.srp_pulse;
  assign soft_disconnect = s_r.disc_pulse;
  assign hnp_start       = s_r.hnp_pulse;

  // Per-endpoint link flags
  always_comb begin
    for (int i = 0; i < `NUM_EP; i++) begin
      tx_not_empty[i] = (fifo_level(s_r.tx_wp[i], s_r.tx_rp[i]) != 3'h0);
      rx_space[i]     = (fifo_level(s_r.rx_wp[i], s_r.rx_rp[i]) != `FIFO_FULL_LVL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence csr_write_seq;
    in_wr && (s_r.addr == `OFS_EP0_STATUS);
  endsequence

  sequence read_take_seq;
    addr_take && !hwrite;
  endsequence

  a_read_wait_state: assert property (read_take_seq |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  a_tx_push_level: assert property (in_wr && addr_is_fifo && !tx_pop && !ctrl_end &&
      fifo_level(s_r.tx_wp[addr_ep], s_r.tx_rp[addr_ep]) != `FIFO_FULL_LVL |=>
      fifo_level(s_r.tx_wp[$past(addr_ep)], s_r.tx_rp[$past(addr_ep)]) ==
      3'($past(fifo_level(s_r.tx_wp[addr_ep], s_r.tx_rp[addr_ep])) + 3'h1))
    else $error("transmit FIFO write did not add one word");

  a_rx_flag_set: assert property (ep0_rx_packet |=> s_r.rx_rdy && ep0_event)
    else $error("receive-ready not set by packet arrival");

  a_rx_ack_clear: assert property (csr_write_seq and (hwdata[`CS_RX_ACK] && !ep0_rx_packet) |=>
      !s_r.rx_rdy ##1 (s_r.rx_rdy == $past(ep0_rx_packet)))
    else $error("receive acknowledge did not clear the flag");

  a_tx_sent_clear: assert property (ep0_tx_sent |=> !s_r.tx_rdy && ep0_event)
    else $error("transmit-ready not cleared after send");

  a_stall_cycle: assert property (stall_transmitted |=> s_r.stall_sent && !stall_request)
    else $error("stall handshake not recorded");

  a_early_end_flush: assert property (ctrl_end && !s_r.last_data && !ep0_tx_sent |=>
      s_r.early_end && !s_r.last_data && !tx_not_empty[0])
    else $error("early control end not handled");

  a_flush_flags: assert property (csr_write_seq and (hwdata[`CS_FLUSH] && (s_r.tx_rdy || s_r.rx_rdy) &&
      !hwdata[`CS_TX_READY] && !ep0_rx_packet) |=> !s_r.tx_rdy && !s_r.rx_rdy && s_r.rx_count == 7'h00)
    else $error("flush left a ready flag set");

  a_b_session_start: assert property (otg_role_b && b_session_start |=> session_level [*1])
    else $error("B-device session start not shown");

  a_hnp_done_clear: assert property (hnp_done |=> !s_r.host_req && !hnp_start)
    else $error("host request not cleared on negotiation done");

  sequence ctl_write_seq;
    in_wr && (s_r.addr == `OFS_DEV_CONTROL);
  endsequence

  sequence ctl_read_seq;
    addr_take && !hwrite && (haddr[4:0] == `OFS_DEV_CONTROL);
  endsequence

  sequence status_read_seq;
    addr_take && !hwrite && (haddr[4:0] == `OFS_EP0_STATUS);
  endsequence

  a_session_a_write: assert property (ctl_write_seq and (!otg_role_b) |=>
      session_level == $past(hwdata[`DC_SESSION]) && !s_r.host_req)
    else $error("A-device session write not applied");

  a_srp_request: assert property (ctl_write_seq and (otg_role_b && hwdata[`DC_SESSION] && !s_r.session &&
      !b_session_end) |=> session_level && srp_start)
    else $error("session request not started");

  a_b_disconnect: assert property (ctl_write_seq and (otg_role_b && !hwdata[`DC_SESSION] && s_r.session &&
      suspended && !b_session_start) |=> !session_level && soft_disconnect)
    else $error("software disconnect not performed");

  a_hnp_single_pulse: assert property (hnp_start |=> !hnp_start)
    else $error("negotiation start longer than one cycle");

  // Read data shows the status sources as they stood in the wait cycle
  a_status_view: assert property (ctl_read_seq |=> ##1
      hrdata[`DC_HOST_MODE] == $past(role_is_host) && hrdata[`DC_VBUS_HI:`DC_VBUS_LO] == $past(vbus_level) &&
      hrdata[`DC_SLOW] == $past(slow_attach) && hrdata[`DC_FULL] == $past(full_attach && role_is_host) &&
      hrdata[`DC_ROLE_B] == $past(otg_role_b))
    else $error("device control status bits wrong");

  a_strobes_read_zero: assert property (status_read_seq |=> ##1
      !hrdata[`CS_RX_ACK] && !hrdata[`CS_END_ACK] && !hrdata[`CS_FLUSH])
    else $error("self-clearing strobe read back as one");

  a_last_data_clear: assert property (ctrl_end |=> !last_data_level)
    else $error("last-data not cleared at control end");

  a_stall_request_set: assert property (csr_write_seq and (hwdata[`CS_STALL_REQ] && !stall_transmitted) |=>
      stall_request)
    else $error("stall request not raised");

endmodule // usb_otg_otg_device_control_ep0_control
`default_nettype wire

// ---- bench/usb_link_model.sv ----
// Behavioural link and cable partner that feeds the endpoint 0 block
`timescale 1ns/1ns
`default_nettype none
module usb_link_model (
  input  wire logic        clk,
  input  wire logic [31:0] tx_word,
  output logic             tx_pop,
  output logic [1:0]       tx_pop_ep,
  output logic             rx_push,
  output logic [1:0]       rx_push_ep,
  output logic [31:0]      rx_word,
  output logic [2:0]       rx_push_bytes,
  output logic [6:0]       evt
);
  // Quiet lines at time zero
  initial begin
    {tx_pop, tx_pop_ep, rx_push, rx_push_ep, rx_word, rx_push_bytes, evt} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive push; released data shows the inverse so stale bits never match
  task automatic push(input logic [1:0] ep, input logic [31:0] w, input logic [2:0] nb);
    rx_push <= 1'b1;
    rx_push_ep <= ep;
    rx_word <= w;
    rx_push_bytes <= nb;
    @(posedge clk);
    rx_push <= 1'b0;
    rx_word <= ~w;
    @(posedge clk);
  endtask

  // Take the head word at the edge that pops it
  task automatic pop(input logic [1:0] ep, output logic [31:0] w);
    tx_pop <= 1'b1;
    tx_pop_ep <= ep;
    @(posedge clk);
    w = tx_word;
    tx_pop <= 1'b0;
    @(posedge clk);
  endtask

  // One-cycle event: packet in, packet sent, stall sent, control end, cable events
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge clk);
    evt <= 7'h00;
    @(posedge clk);
  endtask
endmodule // usb_link_model
`default_nettype wire

// ---- bench/usb_otg_otg_device_control_ep0_control_tb.sv ----
// Self-checking testbench of the endpoint FIFO, device control and endpoint 0 block
`timescale 1ns/1ns
`default_nettype none
`include "usb_ep0_params.svh"
module usb_otg_otg_device_control_ep0_control_tb;
  logic        clk, srst, hsel, hwrite, rd_act, hreadyout, hresp, tx_pop, rx_push;
  logic [31:0] haddr, hwdata, hrdata, tx_word, rx_word, r, v;
  logic [1:0]  htrans, tx_pop_ep, rx_push_ep, vbus_level;
  logic [2:0]  rx_push_bytes, hsize;
  logic [3:0]  tx_not_empty, rx_space;
  logic [6:0]  evt;
  logic        stall_request, tx_ready_level, last_data_level, ep0_event, session_level;
  logic        otg_role_b, role_is_host, slow_attach, full_attach, suspended;
  logic        srp_start, soft_disconnect, hnp_start;
  int          mismatches, n_tests, n_srp, n_dis, n_hnp, n_evt;
  logic [31:0] expq[$];
  logic [31:0] w[5];

  usb_otg_otg_device_control_ep0_control u_dut (
    .clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .tx_pop, .tx_pop_ep, .tx_word, .tx_not_empty, .rx_push,
    .rx_push_ep, .rx_word, .rx_push_bytes, .rx_space, .ep0_rx_packet(evt[0]), .ep0_tx_sent(evt[1]),
    .stall_transmitted(evt[2]), .ctrl_end(evt[3]), .stall_request, .tx_ready_level,
    .last_data_level, .ep0_event, .otg_role_b, .vbus_level, .role_is_host, .slow_attach,
    .full_attach, .suspended, .b_session_start(evt[4]), .b_session_end(evt[5]),
    .hnp_done(evt[6]), .session_level, .srp_start, .soft_disconnect, .hnp_start);

  usb_link_model u_link (
    .clk, .tx_word, .tx_pop, .tx_pop_ep, .rx_push, .rx_push_ep, .rx_word, .rx_push_bytes, .evt);

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Read results are taken off the queue at the edge that ends the data phase
  always @(posedge clk) begin
    if (rd_act && hreadyout) begin
      chk(hrdata, expq.pop_front());
      chk(32'(hresp), 32'h0);
    end
  end

  // Pulse tallies; only whole pulses seen after reset count
  always @(posedge clk) begin
    if (!srst) begin
      n_srp <= n_srp + int'(srp_start);
      n_dis <= n_dis + int'(soft_disconnect);
      n_hnp <= n_hnp + int'(hnp_start);
      n_evt <= n_evt + int'(ep0_event);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite master: hold each phase until hready is seen high at an edge
  task automatic aph(input logic [4:0] a, input logic wrt);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wrt;
    hsize <= 3'h2;
    haddr <= {27'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    aph(a, 1'b1);
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    aph(a, 1'b0);
    expq.push_back(e);
    rd_act <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_act <= 1'b0;
  endtask

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(21066));
    {hsel, hwrite, rd_act, haddr, hwdata, htrans, hsize} = '0;
    {otg_role_b, full_attach, slow_attach, vbus_level, role_is_host, suspended} = '0;
    srst = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`OFS_DEV_CONTROL, 32'h0);
    rd(`OFS_EP0_STATUS, 32'h0);
    rd(`OFS_EP0_COUNT, 32'h0);
    // Status bits follow their sources; full-speed only counts in host role
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      {otg_role_b, full_attach, slow_attach, vbus_level, role_is_host} <= r[5:0];
      repeat (2) @(posedge clk);
      rd(`OFS_DEV_CONTROL, {24'h0, r[5], r[4] & r[0], r[3:1], r[0], 2'h0});
    end
    {otg_role_b, full_attach, slow_attach, vbus_level, role_is_host} <= 6'h00;
    // A device: software owns the session, host request is meaningless
    wr(`OFS_DEV_CONTROL, 32'h03);
    rd(`OFS_DEV_CONTROL, 32'h01);
    chk(32'(session_level), 32'h1);
    wr(`OFS_DEV_CONTROL, 32'h00);
    rd(`OFS_DEV_CONTROL, 32'h00);
    // B device: request, hardware session, negotiation, disconnect
    otg_role_b <= 1'b1;
    wr(`OFS_DEV_CONTROL, 32'h01);
    repeat (3) @(posedge clk);
    chk(n_srp, 32'h1);
    u_link.pulse(4);
    rd(`OFS_DEV_CONTROL, 32'h81);
    suspended <= 1'b1;
    wr(`OFS_DEV_CONTROL, 32'h03);
    rd(`OFS_DEV_CONTROL, 32'h83);
    chk(n_hnp, 32'h1);
    u_link.pulse(6);
    rd(`OFS_DEV_CONTROL, 32'h81);
    wr(`OFS_DEV_CONTROL, 32'h00);
    rd(`OFS_DEV_CONTROL, 32'h80);
    chk(n_dis, 32'h1);
    u_link.pulse(4);
    u_link.pulse(5);
    rd(`OFS_DEV_CONTROL, 32'h80);
    {otg_role_b, suspended} <= 2'h0;
    // Endpoint 0 receive: count, pop, serviced strobe
    w[0] = $urandom;
    w[1] = $urandom;
    u_link.push(2'h0, w[0], 3'h4);
    u_link.push(2'h0, w[1], 3'h3);
    u_link.pulse(0);
    rd(`OFS_EP0_STATUS, 32'h01);
    rd(`OFS_EP0_COUNT, 32'h07);
    rd(`OFS_FIFO_EP0, w[0]);
    rd(`OFS_EP0_COUNT, 32'h03);
    wr(`OFS_EP0_STATUS, 32'h40);
    rd(`OFS_EP0_STATUS, 32'h00);
    rd(`OFS_FIFO_EP0, w[1]);
    // Endpoint 0 transmit with last-data, then an early control end
    wr(`OFS_FIFO_EP0, w[0]);
    wr(`OFS_EP0_STATUS, 32'h0A);
    rd(`OFS_EP0_STATUS, 32'h0A);
    chk(32'({tx_ready_level, last_data_level}), 32'h3);
    u_link.pop(2'h0, v);
    chk(v, w[0]);
    u_link.pulse(1);
    rd(`OFS_EP0_STATUS, 32'h08);
    u_link.pulse(3);
    rd(`OFS_EP0_STATUS, 32'h00);
    wr(`OFS_FIFO_EP0, w[1]);
    wr(`OFS_EP0_STATUS, 32'h02);
    u_link.pulse(3);
    rd(`OFS_EP0_STATUS, 32'h10);
    chk(32'(tx_not_empty[0]), 32'h0);
    chk(n_evt, 32'h3);
    wr(`OFS_EP0_STATUS, 32'h80);
    rd(`OFS_EP0_STATUS, 32'h00);
    // Stall request and sticky stall-sent
    wr(`OFS_EP0_STATUS, 32'h20);
    rd(`OFS_EP0_STATUS, 32'h20);
    chk(32'(stall_request), 32'h1);
    u_link.pulse(2);
    rd(`OFS_EP0_STATUS, 32'h04);
    rd(`OFS_EP0_STATUS, 32'h04);
    wr(`OFS_EP0_STATUS, 32'h00);
    rd(`OFS_EP0_STATUS, 32'h00);
    // Flush does nothing without a ready flag, empties the FIFO with one
    wr(`OFS_FIFO_EP0, w[0]);
    wr(`OFS_EP0_STATUS, 32'h100);
    @(posedge clk);
    chk(32'(tx_not_empty[0]), 32'h1);
    wr(`OFS_EP0_STATUS, 32'h02);
    wr(`OFS_EP0_STATUS, 32'h100);
    rd(`OFS_EP0_STATUS, 32'h00);
    chk(32'(tx_not_empty[0]), 32'h0);
    // Unmapped place reads zero and ignores writes
    wr(5'h1C, 32'hFFFFFFFF);
    rd(5'h1C, 32'h0);
    // Every endpoint: fill past full in both directions, drain in order
    for (int e = 0; e < 4; e++) begin
      for (int i = 0; i < 5; i++) begin
        w[i] = $urandom;
        wr(5'(e * 4), w[i]);
      end
      for (int i = 0; i < 4; i++) begin
        u_link.pop(2'(e), v);
        chk(v, w[i]);
      end
      chk(32'(tx_not_empty[e]), 32'h0);
      for (int i = 0; i < 5; i++) begin
        w[i] = $urandom;
        u_link.push(2'(e), w[i], 3'h4);
      end
      chk(32'(rx_space[e]), 32'h0);
      for (int i = 0; i < 4; i++) rd(5'(e * 4), w[i]);
      @(posedge clk);
      chk(32'(rx_space[e]), 32'h1);
    end
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule // usb_otg_otg_device_control_ep0_control_tb
`default_nettype wire
